/* rtl/dtc_regs.svh */
// Register offsets, field positions and timing counts of the dual timer/counter
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_OFS_CTRL 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_LOW0 8'h8A
`define DTC_OFS_LOW1 8'h8B
`define DTC_OFS_HIGH0 8'h8C
`define DTC_OFS_HIGH1 8'h8D

`define DTC_CTRL_OVF1 7
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_EXT1 3
`define DTC_CTRL_TYPE1 2
`define DTC_CTRL_EXT0 1
`define DTC_CTRL_TYPE0 0

`define DTC_MODE_GATE1 7
`define DTC_MODE_SEL1 6
`define DTC_MODE_FLD1_HI 5
`define DTC_MODE_FLD1_LO 4
`define DTC_MODE_GATE0 3
`define DTC_MODE_SEL0 2
`define DTC_MODE_FLD0_HI 1
`define DTC_MODE_FLD0_LO 0

`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_RESET 8'h00
`define DTC_CNT_RESET 8'h00

`define DTC_MC_CLOCKS 12
`define DTC_MC_CNT_W 4

`endif

/* rtl/dtc_pkg.sv */
// Types shared by the dual timer/counter files
`default_nettype none
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE13,
        DTC_MODE16,
        DTC_MODE8AR,
        DTC_MODESPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dtc_sfr_req_s;

    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } dtc_cnt_s;

    typedef struct packed {
        logic ovf1;
        logic ovf0;
        logic ext1;
        logic ext0;
    } dtc_ack_s;

endpackage
`default_nettype wire

/* rtl/dtc_mc_div.sv */
// Machine-cycle divider: one enable pulse every twelve clocks
`include "dtc_regs.svh"
`default_nettype none
module dtc_mc_div (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Machine-cycle enable
    output logic mc_tick
);
    logic [`DTC_MC_CNT_W-1:0] cnt_reg;
    logic [`DTC_MC_CNT_W-1:0] cnt_next;
    wire last = (cnt_reg == `DTC_MC_CNT_W'(`DTC_MC_CLOCKS - 1));

    assign cnt_next = last ? '0 : cnt_reg + `DTC_MC_CNT_W'(1);
    assign mc_tick = last;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule
`default_nettype wire

/* rtl/dtc_edge_sync.sv */
// Pin synchroniser with machine-cycle sampling and falling-edge pulse
`default_nettype none
module dtc_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Machine-cycle enable
    input wire logic mc_tick,
    // Pin
    input wire logic pin,
    // Results
    output logic level,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic smp_reg;
    logic fall_reg;

    // Idle high so reset itself is never taken as an edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            smp_reg <= 1'b1;
            fall_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            fall_reg <= mc_tick & smp_reg & ~sync_reg;
            if (mc_tick)
                smp_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fall = fall_reg;
endmodule
`default_nettype wire

/* rtl/dtc_top.sv */
// Dual 16-bit timer/counter with external interrupt flags, SFR reachable
`include "dtc_regs.svh"
`default_nettype none
// Function
// - Two independent 16-bit timer/counters
// - Timer increments once per twelve clocks
// - Counter increments on count input falling edge
// - Edge recognised over two machine cycles
// - Two-bit mode field selects four modes
// - Mode 0: 13-bit, upper low bits zero
// - Mode 2: low byte reloads from high
// - Timer 1 mode 3 stops timer 1
// - Timer 0 mode 3: two 8-bit counters
// - Split: high byte uses run one, flag one
// - Gate and run count interrupt input edges
// - Select bit: 1 counter, 0 timer
// - Mode fields at bits 5:4 and 1:0
// - Run bits start and stop timers
// - Overflow flags set, cleared by software or ack
// - External edge flags set on falling edge
// - Type bit selects edge or level
// - Type 0 level, type 1 falling edge
module dtc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // SFR access
    input wire dtc_pkg::dtc_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    // Pins
    input wire logic count_input_zero,
    input wire logic count_input_one,
    input wire logic ext_irq_input_zero,
    input wire logic ext_irq_input_one,
    // Interrupt processed acknowledges
    input wire dtc_pkg::dtc_ack_s irq_ack,
    // Interrupt requests
    output logic overflow_flag_zero,
    output logic overflow_flag_one,
    output logic ext_edge_flag_zero,
    output logic ext_edge_flag_one
);
    // Byte increment with carry, shared by 8-bit modes and split high byte
    function automatic logic [8:0] inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    // Write strobe for one mapped offset
    function automatic logic wr_hit(input dtc_pkg::dtc_sfr_req_s q, input logic [7:0] a);
        return q.wr & (q.addr == a);
    endfunction

    // Two-bit mode field to mode; every code is legal
    function automatic dtc_pkg::dtc_mode_e mode_of(input logic [1:0] f);
        return dtc_pkg::dtc_mode_e'(f);
    endfunction

    // Upper low-byte bits stay zero in 13-bit mode, even after a write
    function automatic logic [7:0] clamp13(input dtc_pkg::dtc_mode_e m, input logic [7:0] v);
        return (m == dtc_pkg::DTC_MODE13) ? {3'h0, v[4:0]} : v;
    endfunction

    // Set wins over clear, so an event in the clearing cycle is never lost
    function automatic logic flag_upd(input logic set, input logic keep, input logic clr);
        return set | (keep & ~clr);
    endfunction

    function automatic dtc_pkg::dtc_cnt_s step(input dtc_pkg::dtc_mode_e m,
                                               input logic [7:0] tl, input logic [7:0] th);
        dtc_pkg::dtc_cnt_s r;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        s13 = {1'b0, th, tl[4:0]} + 14'h0001;
        s16 = {1'b0, th, tl} + 17'h0_0001;
        s8 = inc8(tl);
        unique case (m)
            dtc_pkg::DTC_MODE13:
            begin
                r.tl = {3'h0, s13[4:0]};
                r.th = s13[12:5];
                r.ovf = s13[13];
            end
            dtc_pkg::DTC_MODE16:
            begin
                r.tl = s16[7:0];
                r.th = s16[15:8];
                r.ovf = s16[16];
            end
            dtc_pkg::DTC_MODE8AR:
            begin
                r.tl = s8[8] ? th : s8[7:0];
                r.ovf = s8[8];
            end
            dtc_pkg::DTC_MODESPLIT:
            begin
                r.tl = s8[7:0];
                r.ovf = s8[8];
            end
        endcase
        return r;
    endfunction

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] mode_reg;
    logic [7:0] tl0_reg;
    logic [7:0] tl0_next;
    logic [7:0] th0_reg;
    logic [7:0] th0_next;
    logic [7:0] tl1_reg;
    logic [7:0] tl1_next;
    logic [7:0] th1_reg;
    logic [7:0] th1_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic mc_tick;
    logic cnt0_fall;
    logic cnt1_fall;
    logic ext0_lvl;
    logic ext0_fall;
    logic ext1_lvl;
    logic ext1_fall;

    dtc_mc_div u_div (
        .clk(clk),
        .rstn(rstn),
        .mc_tick(mc_tick)
    );

    // Two-flop sync plus per-machine-cycle sample: two cycles to see a fall
    dtc_edge_sync u_cnt0 (
        .clk(clk),
        .rstn(rstn),
        .mc_tick(mc_tick),
        .pin(count_input_zero),
        .level(),
        .fall(cnt0_fall)
    );
    dtc_edge_sync u_cnt1 (
        .clk(clk),
        .rstn(rstn),
        .mc_tick(mc_tick),
        .pin(count_input_one),
        .level(),
        .fall(cnt1_fall)
    );
    dtc_edge_sync u_ext0 (
        .clk(clk),
        .rstn(rstn),
        .mc_tick(mc_tick),
        .pin(ext_irq_input_zero),
        .level(ext0_lvl),
        .fall(ext0_fall)
    );
    dtc_edge_sync u_ext1 (
        .clk(clk),
        .rstn(rstn),
        .mc_tick(mc_tick),
        .pin(ext_irq_input_one),
        .level(ext1_lvl),
        .fall(ext1_fall)
    );

    // Register decode
    wire wr_ctrl = wr_hit(sfr_req, `DTC_OFS_CTRL);
    wire wr_mode = wr_hit(sfr_req, `DTC_OFS_MODE);
    wire wr_tl0 = wr_hit(sfr_req, `DTC_OFS_LOW0);
    wire wr_tl1 = wr_hit(sfr_req, `DTC_OFS_LOW1);
    wire wr_th0 = wr_hit(sfr_req, `DTC_OFS_HIGH0);
    wire wr_th1 = wr_hit(sfr_req, `DTC_OFS_HIGH1);

    // Mode fields
    wire dtc_pkg::dtc_mode_e mode0 =
        mode_of(mode_reg[`DTC_MODE_FLD0_HI:`DTC_MODE_FLD0_LO]);
    wire dtc_pkg::dtc_mode_e mode1 =
        mode_of(mode_reg[`DTC_MODE_FLD1_HI:`DTC_MODE_FLD1_LO]);
    wire gate0 = mode_reg[`DTC_MODE_GATE0];
    wire gate1 = mode_reg[`DTC_MODE_GATE1];
    wire sel0 = mode_reg[`DTC_MODE_SEL0];
    wire sel1 = mode_reg[`DTC_MODE_SEL1];
    wire run0 = ctrl_reg[`DTC_CTRL_RUN0];
    wire run1 = ctrl_reg[`DTC_CTRL_RUN1];
    wire split = (mode0 == dtc_pkg::DTC_MODESPLIT);

    // Count event selection
    wire src0 = sel0 ? cnt0_fall : mc_tick;
    wire src1 = sel1 ? cnt1_fall : mc_tick;
    wire ev0 = gate0 ? ext0_fall : src0;
    wire ev1 = gate1 ? ext1_fall : src1;
    wire inc0 = run0 & ev0;
    wire inc1 = run1 & ev1 & (mode1 != dtc_pkg::DTC_MODESPLIT);
    wire inc_hi0 = split & run1 & mc_tick;

    // Next count values
    wire dtc_pkg::dtc_cnt_s t0 = step(mode0, tl0_reg, th0_reg);
    wire dtc_pkg::dtc_cnt_s t1 = step(mode1, tl1_reg, th1_reg);
    wire [8:0] hi0_sum = inc8(th0_reg);
    wire ovf0 = inc0 & t0.ovf;
    wire ovf1_t1 = inc1 & t1.ovf & ~split;
    wire ovf1_hi = inc_hi0 & hi0_sum[8];
    wire ovf1 = ovf1_t1 | ovf1_hi;

    // Software write takes the byte it targets over a same-cycle count
    always_comb
    begin
        tl0_next = inc0 ? t0.tl : tl0_reg;
        th0_next = th0_reg;
        if (split)
            th0_next = inc_hi0 ? hi0_sum[7:0] : th0_reg;
        else if (inc0)
            th0_next = t0.th;
        if (wr_tl0)
            tl0_next = sfr_req.wdata;
        if (wr_th0)
            th0_next = sfr_req.wdata;
        tl0_next = clamp13(mode0, tl0_next);
    end

    always_comb
    begin
        tl1_next = inc1 ? t1.tl : tl1_reg;
        th1_next = inc1 ? t1.th : th1_reg;
        if (wr_tl1)
            tl1_next = sfr_req.wdata;
        if (wr_th1)
            th1_next = sfr_req.wdata;
        tl1_next = clamp13(mode1, tl1_next);
    end

    // Flag sources; level type mirrors the low input
    wire set_ext0 = ctrl_reg[`DTC_CTRL_TYPE0] ? ext0_fall : ~ext0_lvl;
    wire set_ext1 = ctrl_reg[`DTC_CTRL_TYPE1] ? ext1_fall : ~ext1_lvl;
    wire [7:0] ctrl_base = wr_ctrl ? sfr_req.wdata : ctrl_reg;

    // Hardware set wins over both software clear and acknowledge
    always_comb
    begin
        ctrl_next = ctrl_base;
        ctrl_next[`DTC_CTRL_OVF0] =
            flag_upd(ovf0, ctrl_base[`DTC_CTRL_OVF0], irq_ack.ovf0);
        ctrl_next[`DTC_CTRL_OVF1] =
            flag_upd(ovf1, ctrl_base[`DTC_CTRL_OVF1], irq_ack.ovf1);
        ctrl_next[`DTC_CTRL_EXT0] =
            flag_upd(set_ext0, ctrl_base[`DTC_CTRL_EXT0], irq_ack.ext0);
        ctrl_next[`DTC_CTRL_EXT1] =
            flag_upd(set_ext1, ctrl_base[`DTC_CTRL_EXT1], irq_ack.ext1);
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        unique case (sfr_req.addr)
            `DTC_OFS_CTRL: rdata_next = ctrl_reg;
            `DTC_OFS_MODE: rdata_next = mode_reg;
            `DTC_OFS_LOW0: rdata_next = tl0_reg;
            `DTC_OFS_LOW1: rdata_next = tl1_reg;
            `DTC_OFS_HIGH0: rdata_next = th0_reg;
            `DTC_OFS_HIGH1: rdata_next = th1_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg <= `DTC_CTRL_RESET;
            mode_reg <= `DTC_MODE_RESET;
            tl0_reg <= `DTC_CNT_RESET;
            th0_reg <= `DTC_CNT_RESET;
            tl1_reg <= `DTC_CNT_RESET;
            th1_reg <= `DTC_CNT_RESET;
            rdata_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            if (wr_mode)
                mode_reg <= sfr_req.wdata;
            tl0_reg <= tl0_next;
            th0_reg <= th0_next;
            tl1_reg <= tl1_next;
            th1_reg <= th1_next;
            if (sfr_req.rd)
                rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign overflow_flag_zero = ctrl_reg[`DTC_CTRL_OVF0];
    assign overflow_flag_one = ctrl_reg[`DTC_CTRL_OVF1];
    assign ext_edge_flag_zero = ctrl_reg[`DTC_CTRL_EXT0];
    assign ext_edge_flag_one = ctrl_reg[`DTC_CTRL_EXT1];
endmodule
`default_nettype wire

/* bench/dtc_chk.sv */
// Port checker for the dual timer/counter and its bind
`default_nettype none
module dtc_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access
    input wire dtc_pkg::dtc_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Pin and acknowledges
    input wire logic ext_irq_input_zero,
    input wire dtc_pkg::dtc_ack_s irq_ack,
    // Flags
    input wire logic overflow_flag_zero,
    input wire logic overflow_flag_one,
    input wire logic ext_edge_flag_zero,
    input wire logic ext_edge_flag_one
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire logic ctrl_wr = sfr_req.wr && sfr_req.addr == 8'h88;
    wire logic ctrl_rd = sfr_req.rd && sfr_req.addr == 8'h88;
    wire logic mode_wr = sfr_req.wr && sfr_req.addr == 8'h89;
    wire logic mode_rd = sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h89;
    wire logic [3:0] fl = {overflow_flag_one, overflow_flag_zero, ext_edge_flag_one,
        ext_edge_flag_zero};
    // Run one, run zero, type zero: only software changes them
    logic [2:0] sw_reg;
    // Clocks since the pin was last low; covers sync and sampling delay
    logic [5:0] age_reg;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) sw_reg <= 3'h0;
        else if (ctrl_wr) sw_reg <= {sfr_req.wdata[6], sfr_req.wdata[4], sfr_req.wdata[0]};
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) age_reg <= 6'h00;
        else age_reg <= ext_irq_input_zero ? age_reg + {5'h00, age_reg != 6'h3F} : 6'h00;
    property p_rb; mode_wr ##1 mode_rd |=> sfr_rdata == $past(sfr_req.wdata, 2); endproperty
    a_rb: assert property (p_rb) else $error("mode readback wrong");
    property p_crd; ctrl_rd |=> {sfr_rdata[7], sfr_rdata[5], sfr_rdata[3], sfr_rdata[1]}
        == $past(fl); endproperty
    a_crd: assert property (p_crd) else $error("flag bits read wrong");
    property p_run0; !$past(sw_reg[1]) && !$past(sw_reg[1], 2) && !$past(ctrl_wr)
        |-> !$rose(overflow_flag_zero); endproperty
    a_run0: assert property (p_run0) else $error("overflow zero while stopped");
    property p_run1; !$past(sw_reg[2]) && !$past(sw_reg[2], 2) && !$past(ctrl_wr)
        |-> !$rose(overflow_flag_one); endproperty
    a_run1: assert property (p_run1) else $error("overflow one while stopped");
    property p_clr; ctrl_wr && !sfr_req.wdata[5] && !sw_reg[1] && !$past(sw_reg[1])
        |=> !overflow_flag_zero; endproperty
    a_clr: assert property (p_clr) else $error("overflow zero not cleared");
    property p_ack; irq_ack.ext0 && !ctrl_wr && sw_reg[0] && age_reg > 6'h28
        |=> !ext_edge_flag_zero; endproperty
    a_ack: assert property (p_ack) else $error("edge flag not cleared");
    property p_lvl; (!sw_reg[0] && !ext_irq_input_zero && !irq_ack.ext0 && !ctrl_wr) [*5]
        |=> ext_edge_flag_zero; endproperty
    a_lvl: assert property (p_lvl) else $error("low level not flagged");
    property p_src; $rose(ext_edge_flag_zero) |-> $past(ctrl_wr) || age_reg < 6'h20;
    endproperty
    a_src: assert property (p_src) else $error("edge flag without low pin");
endmodule
bind dtc_top dtc_chk chk_u (.clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .ext_irq_input_zero(ext_irq_input_zero), .irq_ack(irq_ack),
    .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one),
    .ext_edge_flag_zero(ext_edge_flag_zero), .ext_edge_flag_one(ext_edge_flag_one));
`default_nettype wire

/* bench/dtc_pins.sv */
// Pin-side source model for count and interrupt inputs
`default_nettype none
module dtc_pins (
    // Clock
    input wire logic clk,
    // Pins, idle high
    output logic count_input_zero,
    output logic count_input_one,
    output logic ext_irq_input_zero,
    output logic ext_irq_input_one
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pin_reg = 4'hF;
    assign {ext_irq_input_one, ext_irq_input_zero, count_input_one, count_input_zero} = pin_reg;
    task automatic level(input int i, input logic v);
        pin_reg[i] = v;
    endtask
    // Each level stands h clocks; below 12 the device may miss it
    task automatic pulse(input int i, input int n, input int h);
        repeat (n)
        begin
            level(i, 1'b0);
            repeat (h) @(posedge clk) #1;
            level(i, 1'b1);
            repeat (h) @(posedge clk) #1;
        end
    endtask
endmodule
`default_nettype wire

/* bench/test_dtc_top.sv */
// Self-checking bench for the dual timer/counter
`default_nettype none
module test_dtc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    dtc_pkg::dtc_sfr_req_s sfr_req = '0;
    dtc_pkg::dtc_ack_s irq_ack = '0;
    wire [7:0] rdata;
    wire [3:0] pin;
    wire [3:0] flag;
    int err_count = 0;
    int tests_run = 0;
    int n;
    always #20 clk = ~clk;
    dtc_pins pins_u (.clk(clk), .count_input_zero(pin[0]), .count_input_one(pin[1]),
        .ext_irq_input_zero(pin[2]), .ext_irq_input_one(pin[3]));
    dtc_top dut_u (.clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(rdata),
        .count_input_zero(pin[0]), .count_input_one(pin[1]), .ext_irq_input_zero(pin[2]),
        .ext_irq_input_one(pin[3]), .irq_ack(irq_ack), .overflow_flag_zero(flag[2]),
        .overflow_flag_one(flag[3]), .ext_edge_flag_zero(flag[0]), .ext_edge_flag_one(flag[1]));
    task automatic tick(input int k);
        sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b0;
        repeat (k) @(posedge clk) #1;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk) #1;
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk) #1;
        check($sformatf("register %h", a), e, rdata);
    endtask
    task automatic look(input int k, input logic e);
        check($sformatf("flag %0d", k), {7'h00, e}, {7'h00, flag[k]});
    endtask
    task automatic ack(input int k, input logic e);
        irq_ack = dtc_pkg::dtc_ack_s'(4'h1 << k);
        tick(1);
        irq_ack = '0;
        tick(1);
        look(k, e);
    endtask
    task automatic wait_flag(input int k);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (flag[k] !== 1'b1 && n < 60);
        look(k, 1'b1);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Run needs about 500 clocks; twelve times that means a hang
    initial
    begin
        #240000;
        err_count++;
        print_verdict();
    end
    initial
    begin
        tick(12);
        rstn = 1'b1;
        get(8'h88, 8'h00);
        get(8'h89, 8'h00);
        put(8'h89, 8'hA6);
        get(8'h89, 8'hA6);
        get(8'h8E, 8'h00);
        put(8'h89, 8'h01);
        put(8'h8A, 8'hFE);
        put(8'h8C, 8'hFF);
        put(8'h88, 8'h10);
        wait_flag(2);
        put(8'h88, 8'h20);
        check("wrap time", 8'h01, {7'h00, n >= 12 && n <= 26});
        get(8'h8A, 8'h00);
        get(8'h8C, 8'h00);
        get(8'h88, 8'h20);
        tick(30);
        get(8'h8A, 8'h00);
        ack(2, 1'b0);
        put(8'h89, 8'h00);
        put(8'h8A, 8'hFF);
        get(8'h8A, 8'h1F);
        put(8'h8C, 8'hFF);
        put(8'h88, 8'h10);
        wait_flag(2);
        put(8'h88, 8'h00);
        get(8'h8A, 8'h00);
        get(8'h8C, 8'h00);
        put(8'h89, 8'h20);
        put(8'h8D, 8'hF0);
        put(8'h8B, 8'hFF);
        put(8'h88, 8'h40);
        wait_flag(3);
        put(8'h88, 8'h80);
        get(8'h8B, 8'hF0);
        get(8'h8D, 8'hF0);
        ack(3, 1'b0);
        put(8'h89, 8'h33);
        put(8'h8C, 8'hFF);
        put(8'h8A, 8'hFE);
        put(8'h8B, 8'h77);
        put(8'h88, 8'h40);
        wait_flag(3);
        put(8'h88, 8'h80);
        get(8'h8C, 8'h00);
        get(8'h8A, 8'hFE);
        get(8'h8B, 8'h77);
        ack(3, 1'b0);
        get(8'h88, 8'h00);
        put(8'h89, 8'h55);
        put(8'h8A, 8'h00);
        put(8'h8B, 8'h00);
        put(8'h88, 8'h50);
        tick(1);
        pins_u.pulse(0, 3, 12);
        pins_u.pulse(1, 2, 12);
        put(8'h88, 8'h00);
        get(8'h8A, 8'h03);
        get(8'h8B, 8'h02);
        put(8'h89, 8'h09);
        put(8'h8A, 8'h00);
        put(8'h88, 8'h11);
        tick(1);
        pins_u.pulse(2, 2, 12);
        get(8'h88, 8'h13);
        put(8'h88, 8'h03);
        tick(45);
        get(8'h8A, 8'h02);
        ack(0, 1'b0);
        put(8'h88, 8'h00);
        tick(1);
        pins_u.level(2, 1'b0);
        tick(8);
        look(0, 1'b1);
        ack(0, 1'b1);
        pins_u.level(2, 1'b1);
        tick(8);
        ack(0, 1'b0);
        put(8'h88, 8'h04);
        tick(1);
        pins_u.pulse(3, 1, 12);
        look(1, 1'b1);
        ack(1, 1'b0);
        put(8'h89, 8'hA2);
        put(8'h8C, 8'h80);
        put(8'h8A, 8'hFF);
        put(8'h8B, 8'h00);
        put(8'h88, 8'h54);
        wait_flag(2);
        put(8'h88, 8'h44);
        get(8'h8A, 8'h80);
        tick(1);
        pins_u.pulse(3, 2, 12);
        get(8'h8B, 8'h02);
        look(1, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
